/* verif/rhc_master_model.sv */
// Network master model: sends frames, consumes with random stalls.
// Assumes one clock shared with the node.
`timescale 1ns/100ps
module rhc_master_model
  import rhc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       tx_valid,
  input  wire rhc_frame_t tx_frame,
  output      logic       tx_ready,
  output      logic       rx_valid,
  output      rhc_frame_t rx_frame,
  output      logic       got,
  output      rhc_frame_t got_frame
);
  initial {tx_ready, rx_valid, rx_frame, got, got_frame} = '0;
  always @(posedge clk_sys)
  begin
    got       <= tx_valid && tx_ready;
    got_frame <= tx_frame;
    tx_ready  <= $urandom_range(3) != 0;
  end
  task automatic send(input logic [10:0] c, input logic t, input logic [63:0] d);
    @(posedge clk_sys);
    rx_frame <= '{c, t, 4'h8, d};
    rx_valid <= 1'b1;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask : send
endmodule : rhc_master_model

/* verif/rhc_node_chk.sv */
// Port checker for the network node.
// Assumes it is bound to every rhc_node.
`timescale 1ns/100ps
module rhc_node_chk
  import rhc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       od_valid,
  input wire logic       od_ack,
  input wire rhc_state_t net_state,
  input wire logic       tag_wr_valid,
  input wire logic [7:0] node_id,
  input wire logic [7:0] bit_rate_code,
  input wire logic [9:0] bit_rate_kbps,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire rhc_frame_t tx_frame,
  input wire logic       cfg_error,
  input wire logic       bus_error,
  input wire logic       led_green
);
  localparam logic [9:0] KB [8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa,
    10'h07d, 10'h064, 10'h032, 10'h014};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_preop; net_state == ST_PREOP && !cfg_error && !bus_error; endsequence
  sequence s_stall; tx_valid && !tx_ready; endsequence
  chk_od_ack: assert property (od_valid && net_state != ST_STOPPED |=> od_ack)
    else $error("od ack missing");
  chk_stop_silent: assert property (od_valid && net_state == ST_STOPPED |=> !od_ack)
    else $error("od ack while stopped");
  chk_node_range: assert property (node_id >= NODE_MIN && node_id <= NODE_MAX)
    else $error("node id out of range");
  chk_rate_map: assert property (bit_rate_kbps == KB[bit_rate_code[2:0]])
    else $error("bit rate decode wrong");
  chk_pdo_oper: assert property ($past(net_state) != ST_OPER |-> !tag_wr_valid)
    else $error("tag write outside operational");
  chk_boot_frame: assert property ($fell(reset) |-> ##[1:2] tx_valid
    && tx_frame.cob == COB_BOOT + {3'h0, node_id}) else $error("boot frame wrong");
  chk_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_frame))
    else $error("frame lost in stall");
  chk_green_preop: assert property (s_preop [*2] |-> led_green)
    else $error("green dark in preop");
endmodule : rhc_node_chk
bind rhc_node rhc_node_chk u_chk (.*);

/* verif/rhc_node_tb.sv */
// Self-checking bench for the network node.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module rhc_node_tb;
  import rhc_pkg::*;
  logic clk_sys = 0, reset = 1, od_valid = 0, tag_present = 0, tag_new = 0, tag_rd_done = 0;
  logic cfg_error = 0, bus_error = 0, bus_off = 0, hw_fault = 0, ack_exp = 1, er;
  logic rx_valid, tx_valid, tx_ready, od_ack, od_err, tag_rd_valid, tag_wr_valid, got;
  logic led_green, led_red, led_yellow;
  logic [63:0] value_changed = '0, tag_rd_data = '0, tag_wr_data, d;
  logic [31:0] od_rdata, r;
  logic [9:0] bit_rate_kbps;
  logic [7:0] node_id, bit_rate_code, id, sb = 8'h00;
  logic [5:0] tag_rd_pdo, tag_wr_pdo;
  logic [1:0] k;
  rhc_state_t net_state;
  rhc_frame_t rx_frame, tx_frame, got_frame;
  rhc_od_req_t od_req = '0;
  int check_count = 0, n_fail = 0, i;
  localparam logic [9:0] KB [8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa,
    10'h07d, 10'h064, 10'h032, 10'h014};
  rhc_node #(.FAST_HALF(4), .SLOW_HALF(10)) dut (.*);
  rhc_master_model m (.*);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    tag_rd_done <= tag_rd_valid;
    tag_rd_data <= mem(tag_rd_pdo);
  end
  function automatic logic [63:0] mem(input logic [5:0] p);
    for (int b = 0; b < 8; b++) mem[8*b+:8] = {p[4:0], 3'(b)};
  endfunction : mem
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic od(input logic w, input logic [15:0] x, input logic [7:0] v);
    od_req <= '{w, x, sb, {24'h0, v}};
    od_valid <= 1'b1;
    @(posedge clk_sys) od_valid <= 1'b0;
    @(negedge clk_sys);
    `CHK("od_ack", ack_exp, od_ack)
    r = od_rdata;
    er = od_err;
    @(posedge clk_sys);
  endtask : od
  task automatic nmt(input logic [7:0] c);
    m.send(COB_NMT, 1'b0, {56'h0, c});
    repeat (3) @(posedge clk_sys);
  endtask : nmt
  task automatic wt(input logic [10:0] c);
    @(negedge clk_sys);
    for (i = 0; i < 300 && !(got && got_frame.cob == c); i++) @(negedge clk_sys);
    d = got_frame.data;
    @(posedge clk_sys);
    if (i == 300)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask : wt
  initial
  begin
    void'($urandom(89549));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    wt(COB_BOOT + 11'h020);
    `CHK("node_id", 8'h20, node_id)
    `CHK("rate", 8'h04, bit_rate_code)
    od(1'b0, OD_NODE_A, 8'h00);
    `CHK("copy_a", 32'h20, r)
    od(1'b0, 16'h3000, 8'h00);
    `CHK("od_err", 1'b1, er)
    for (int c = 0; c < 8; c++)
    begin
      od(1'b1, OD_RATE_A, 8'(c));
      od(1'b1, OD_RATE_B, 8'(c));
      nmt(NMT_RST_COMM);
      wt(COB_BOOT + 11'h020);
      `CHK("rate", 8'(c), bit_rate_code)
      `CHK("kbps", KB[c], bit_rate_kbps)
    end
    id = 8'($urandom_range(127, 1));
    od(1'b1, OD_NODE_A, id);
    od(1'b1, OD_NODE_B, id);
    od(1'b1, OD_RATE_A, 8'h01);
    od(1'b1, OD_RATE_B, 8'h02);
    nmt(NMT_RST_NODE);
    wt(COB_BOOT + 11'(id));
    `CHK("node_id", id, node_id)
    `CHK("rate", 8'h07, bit_rate_code)
    od(1'b1, OD_NODE_A, 8'h00);
    od(1'b1, OD_NODE_B, 8'h00);
    nmt(NMT_RST_COMM);
    wt(COB_BOOT + 11'(id));
    `CHK("node_id", id, node_id)
    m.send(COB_LSS_RX, 1'b0, 64'h0104);
    m.send(COB_LSS_RX, 1'b0, {48'h0, id, LSS_CFG_NODE});
    wt(COB_LSS_TX);
    `CHK("lss_ok", {56'h0, LSS_CFG_NODE}, d)
    m.send(COB_LSS_RX, 1'b0, {48'h0, 8'h80, LSS_CFG_NODE});
    wt(COB_LSS_TX);
    `CHK("lss_bad", {55'h0, 1'b1, LSS_CFG_NODE}, d)
    tag_present <= 1'b1;
    m.send(COB_RPDO1 + 11'(id), 1'b0, 64'h1);
    nmt(NMT_START);
    `CHK("state", ST_OPER, net_state)
    m.send(COB_TPDO1 + 11'(id), 1'b1, 64'h0);
    wt(COB_TPDO1 + 11'(id));
    `CHK("tpdo0", mem(6'h00), d)
    tag_new <= 1'b1;
    @(posedge clk_sys) tag_new <= 1'b0;
    wt(COB_TPDO1 + 11'h100 + 11'(id));
    `CHK("tpdo1", mem(6'h01), d)
    k = 2'($urandom);
    d = {$urandom, $urandom};
    m.send(COB_RPDO1 + 11'({k, 8'h00}) + 11'(id), 1'b0, d);
    for (i = 0; i < 20 && tag_wr_valid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 20)
    begin
      n_fail++;
      tally_and_finish;
    end
    `CHK("wr_pdo", 6'(k), tag_wr_pdo)
    `CHK("wr_data", d, tag_wr_data)
    repeat (20) @(posedge clk_sys);
    value_changed <= 64'h8;
    @(posedge clk_sys) value_changed <= '0;
    wt(COB_TPDO1 + 11'h300 + 11'(id));
    `CHK("event", mem(6'h03), d)
    sb = SUB_TXTYPE;
    od(1'b1, OD_TPDO_PAR, 8'h02);
    sb = 8'h00;
    repeat (2) m.send(COB_SYNC, 1'b0, 64'h0);
    wt(COB_TPDO1 + 11'(id));
    `CHK("sync", mem(6'h00), d)
    nmt(NMT_STOP);
    `CHK("state", ST_STOPPED, net_state)
    ack_exp = 1'b0;
    od(1'b0, OD_NODE_A, 8'h00);
    `CHK("yellow", 1'b1, led_yellow)
    bus_off <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("red", 1'b1, led_red)
    cfg_error <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("alt", ~led_green, led_red)
    tally_and_finish;
  end
endmodule : rhc_node_tb

/* verilog/rhc_node.sv */
// Network node logic of the RFID read/write head: states, identity, PDOs, LEDs.
// Assumes a CAN controller that hands over whole frames on clk_sys and an
// object dictionary engine that issues single-word requests.
// What this block does
// - Leave reset with node identifier 32 and bit-rate code for 125 kbit/s.
// - Node id copies A and B; store when equal, apply at soft reset.
// - Only node identifiers 1 through 127 are accepted.
// - Bit-rate copies A and B; store when equal, apply at soft reset.
// - Codes 0..7 map to 1000, 800, 500, 250, 125, 100, 50, 20 kbit/s.
// - Layer setting master switches all slaves into configuration mode.
// - Layer setting bit rate acknowledged only if supported.
// - Layer setting node id acknowledged only if valid.
// - Layer setting values apply only after a soft reset.
// - No PDO leaves the node while pre-operational.
// - Boot-up frame 0x700 plus node id is sent on entering pre-operational from initialization.
// - Operational state runs every service, PDO exchange included.
// - Stopped state answers only network management frames.
// - TPDO sent on remote request, else in event mode (type 0xff) whenever its mapped value changes.
// - Synchronous mode sends TPDOs after every n-th SYNC frame.
// - 64 TPDOs and 64 RPDO enable bits, but only RPDOs 0 to 3 are received; first four of each enabled after reset.
// - PDO n carries tag user bytes 8n to 8n+7.
// - A newly detected tag triggers reading and sending all enabled TPDOs.
// - A received RPDO is written to its mapped tag memory area.
// - PDO transfer happens only while operational.
// - Red and green alternate at 2.5 Hz on config error, 0.8 Hz on bus error.
// - Yellow steady with valid tag, irregular on hardware fault, else off.
`timescale 1ns/100ps
module rhc_node #(
  parameter int unsigned FAST_HALF = rhc_pkg::FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = rhc_pkg::SLOW_HALF_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 rx_valid,
  input  wire rhc_pkg::rhc_frame_t  rx_frame,
  output      logic                 tx_valid,
  output      rhc_pkg::rhc_frame_t  tx_frame,
  input  wire logic                 tx_ready,
  input  wire logic                 od_valid,
  input  wire rhc_pkg::rhc_od_req_t od_req,
  output      logic                 od_ack,
  output      logic                 od_err,
  output      logic [31:0]          od_rdata,
  input  wire logic                 tag_present,
  input  wire logic                 tag_new,
  input  wire logic [63:0]          value_changed,
  output      logic                 tag_rd_valid,
  output      logic [5:0]           tag_rd_pdo,
  input  wire logic                 tag_rd_done,
  input  wire logic [63:0]          tag_rd_data,
  output      logic                 tag_wr_valid,
  output      logic [5:0]           tag_wr_pdo,
  output      logic [63:0]          tag_wr_data,
  input  wire logic                 cfg_error,
  input  wire logic                 bus_error,
  input  wire logic                 bus_off,
  input  wire logic                 hw_fault,
  output      rhc_pkg::rhc_state_t  net_state,
  output      logic [7:0]           node_id,
  output      logic [7:0]           bit_rate_code,
  output      logic [9:0]           bit_rate_kbps,
  output      logic                 led_green,
  output      logic                 led_red,
  output      logic                 led_yellow
);
  import rhc_pkg::*;

  function automatic logic id_ok(input logic [7:0] v);
    id_ok = (v >= NODE_MIN) && (v <= NODE_MAX);
  endfunction : id_ok

  function automatic logic [10:0] pdo_cob(input logic [10:0] base, input logic [1:0] k,
                                          input logic [7:0] nid);
    pdo_cob = base + {1'b0, k, 8'h00} + {4'h0, nid[6:0]};
  endfunction : pdo_cob

  function automatic logic in_pdo_range(input logic [15:0] idx, input logic [15:0] base);
    in_pdo_range = (idx[15:6] == base[15:6]);
  endfunction : in_pdo_range

  function automatic logic [5:0] first_one(input logic [63:0] v);
    first_one = 6'h00;
    for (int i = 63; i >= 0; i--)
    begin
      if (v[i])
        first_one = 6'(i);
    end
  endfunction : first_one

  function automatic logic [9:0] kbps_of(input logic [7:0] c);
    case (c[2:0])
      3'h0: kbps_of = 10'd1000;
      3'h1: kbps_of = 10'd800;
      3'h2: kbps_of = 10'd500;
      3'h3: kbps_of = 10'd250;
      3'h4: kbps_of = 10'd125;
      3'h5: kbps_of = 10'd100;
      3'h6: kbps_of = 10'd50;
      default: kbps_of = 10'd20;
    endcase
  endfunction : kbps_of

  rhc_state_t  state_reg;
  rhc_serve_t  serve_reg;
  logic [7:0]  node_a_reg, node_b_reg, rate_a_reg, rate_b_reg;
  logic [7:0]  node_store_reg, rate_store_reg, node_act_reg, rate_act_reg;
  logic        node_chk_reg, rate_chk_reg;
  logic        boot_pend_reg, lss_cfg_reg, lss_pend_reg;
  rhc_frame_t  lss_rsp_reg, pdo_frame_reg;
  logic [63:0] tpdo_ena_reg, rpdo_ena_reg, pend_reg;
  logic [7:0]  tx_type_reg, sync_cnt_reg;
  logic [5:0]  serve_pdo_reg;
  rhc_frame_t  buf_mem [2];
  logic        buf_wr_reg, buf_rd_reg;
  logic [1:0]  buf_cnt_reg;
  logic [31:0] fast_cnt_reg, slow_cnt_reg;
  logic        fast_ph_reg, slow_ph_reg;
  logic [15:0] lfsr_reg;

  logic        live, oper, rx_nmt, soft_rst, rx_lss, rx_sync, od_take, od_wr, sync_fire;
  logic [7:0]  nmt_cmd, lss_cs, lss_b1;
  logic [63:0] pend_set;
  logic [3:0]  rtr_hit, rpdo_hit;
  logic        in_valid, in_ready, take_boot, take_lss, take_pdo;
  rhc_frame_t  in_frame;

  assign live     = (state_reg != ST_STOPPED);
  assign oper     = (state_reg == ST_OPER);
  assign nmt_cmd  = rx_frame.data[7:0];
  assign rx_nmt   = rx_valid && (rx_frame.cob == COB_NMT) && !rx_frame.rtr &&
                    ((rx_frame.data[15:8] == 8'h00) || (rx_frame.data[15:8] == node_act_reg));
  assign soft_rst = rx_nmt && ((nmt_cmd == NMT_RST_NODE) || (nmt_cmd == NMT_RST_COMM));
  assign rx_lss   = rx_valid && live && (rx_frame.cob == COB_LSS_RX);
  assign lss_cs   = rx_frame.data[7:0];
  assign lss_b1   = rx_frame.data[15:8];
  assign rx_sync  = rx_valid && live && (rx_frame.cob == COB_SYNC);
  assign od_take  = od_valid && live;
  assign od_wr    = od_take && od_req.wr;

  // Network state machine; a soft reset reloads the stored identity.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_reg <= ST_INIT;
    else
    begin
      case (state_reg)
        ST_INIT: state_reg <= ST_PREOP;
        default:
        begin
          if (soft_rst)
            state_reg <= ST_INIT;
          else if (rx_nmt && nmt_cmd == NMT_START)
            state_reg <= ST_OPER;
          else if (rx_nmt && nmt_cmd == NMT_STOP)
            state_reg <= ST_STOPPED;
          else if (rx_nmt && nmt_cmd == NMT_PREOP)
            state_reg <= ST_PREOP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      node_act_reg <= NODE_ID_RST;
      rate_act_reg <= RATE_RST;
    end
    else if (state_reg == ST_INIT)
    begin
      node_act_reg <= node_store_reg;
      rate_act_reg <= rate_store_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      boot_pend_reg <= 1'b0;
    else if (state_reg == ST_INIT)
      boot_pend_reg <= 1'b1;
    else if (take_boot || state_reg == ST_STOPPED)
      boot_pend_reg <= 1'b0;
  end

  // Dictionary copies; a match of both copies is checked a cycle after a write.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      node_a_reg   <= NODE_ID_RST;
      node_b_reg   <= NODE_ID_RST;
      rate_a_reg   <= RATE_RST;
      rate_b_reg   <= RATE_RST;
      node_chk_reg <= 1'b0;
      rate_chk_reg <= 1'b0;
    end
    else
    begin
      if (od_wr && od_req.index == OD_NODE_A)
        node_a_reg <= od_req.wdata[7:0];
      if (od_wr && od_req.index == OD_NODE_B)
        node_b_reg <= od_req.wdata[7:0];
      if (od_wr && od_req.index == OD_RATE_A)
        rate_a_reg <= od_req.wdata[7:0];
      if (od_wr && od_req.index == OD_RATE_B)
        rate_b_reg <= od_req.wdata[7:0];
      node_chk_reg <= od_wr && (od_req.index == OD_NODE_A || od_req.index == OD_NODE_B);
      rate_chk_reg <= od_wr && (od_req.index == OD_RATE_A || od_req.index == OD_RATE_B);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      node_store_reg <= NODE_ID_RST;
      rate_store_reg <= RATE_RST;
    end
    else
    begin
      if (rx_lss && lss_cfg_reg && lss_cs == LSS_CFG_NODE && id_ok(lss_b1))
        node_store_reg <= lss_b1;
      else if (node_chk_reg && node_a_reg == node_b_reg && id_ok(node_a_reg))
        node_store_reg <= node_a_reg;
      if (rx_lss && lss_cfg_reg && lss_cs == LSS_CFG_BIT && lss_b1 == 8'h00 &&
          rx_frame.data[23:16] <= RATE_MAX)
        rate_store_reg <= rx_frame.data[23:16];
      else if (rate_chk_reg && rate_a_reg == rate_b_reg && rate_a_reg <= RATE_MAX)
        rate_store_reg <= rate_a_reg;
    end
  end

  // Dictionary answers and PDO configuration.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      od_ack       <= 1'b0;
      od_err       <= 1'b0;
      od_rdata     <= 32'h0000_0000;
      tpdo_ena_reg <= PDO_ENA_RST;
      rpdo_ena_reg <= PDO_ENA_RST;
      tx_type_reg  <= TXTYPE_EVENT;
    end
    else
    begin
      od_ack   <= od_take;
      od_err   <= 1'b0;
      od_rdata <= 32'h0000_0000;
      if (od_take)
      begin
        if (od_req.index == OD_NODE_A)
          od_rdata <= {24'h0, node_a_reg};
        else if (od_req.index == OD_NODE_B)
          od_rdata <= {24'h0, node_b_reg};
        else if (od_req.index == OD_RATE_A)
          od_rdata <= {24'h0, rate_a_reg};
        else if (od_req.index == OD_RATE_B)
          od_rdata <= {24'h0, rate_b_reg};
        else if (od_req.index == OD_STATUS)
          od_rdata <= {13'h0, lss_cfg_reg, state_reg, rate_act_reg, node_act_reg};
        else if (in_pdo_range(od_req.index, OD_TPDO_PAR) && od_req.sub == SUB_COB)
        begin
          od_rdata <= {~tpdo_ena_reg[od_req.index[5:0]], 31'h0};
          if (od_req.wr)
            tpdo_ena_reg[od_req.index[5:0]] <= ~od_req.wdata[31];
        end
        else if (in_pdo_range(od_req.index, OD_TPDO_PAR) && od_req.sub == SUB_TXTYPE)
        begin
          od_rdata <= {24'h0, tx_type_reg};
          if (od_req.wr)
            tx_type_reg <= od_req.wdata[7:0];
        end
        else if (in_pdo_range(od_req.index, OD_RPDO_PAR) && od_req.sub == SUB_COB)
        begin
          od_rdata <= {~rpdo_ena_reg[od_req.index[5:0]], 31'h0};
          if (od_req.wr)
            rpdo_ena_reg[od_req.index[5:0]] <= ~od_req.wdata[31];
        end
        else
          od_err <= 1'b1;
      end
    end
  end

  // Layer setting slave: global switch, node and timing configuration.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lss_cfg_reg  <= 1'b0;
      lss_pend_reg <= 1'b0;
      lss_rsp_reg  <= '0;
    end
    else
    begin
      if (rx_lss && lss_cs == LSS_SWITCH)
        lss_cfg_reg <= (lss_b1 == 8'h01);
      if (rx_lss && lss_cfg_reg && (lss_cs == LSS_CFG_NODE || lss_cs == LSS_CFG_BIT))
      begin
        lss_pend_reg    <= 1'b1;
        lss_rsp_reg.cob <= COB_LSS_TX;
        lss_rsp_reg.rtr <= 1'b0;
        lss_rsp_reg.dlc <= 4'h8;
        if (lss_cs == LSS_CFG_NODE)
          lss_rsp_reg.data <= {48'h0, 7'h0, !id_ok(lss_b1), lss_cs};
        else
          lss_rsp_reg.data <= {48'h0, 7'h0,
                               !(lss_b1 == 8'h00 && rx_frame.data[23:16] <= RATE_MAX),
                               lss_cs};
      end
      else if (take_lss)
        lss_pend_reg <= 1'b0;
    end
  end

  // TPDO triggers: remote request, value change, new tag and SYNC count.
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      rtr_hit[k]  = rx_valid && rx_frame.rtr &&
                    rx_frame.cob == pdo_cob(COB_TPDO1, 2'(k), node_act_reg);
      rpdo_hit[k] = rx_valid && !rx_frame.rtr && rpdo_ena_reg[k] &&
                    rx_frame.cob == pdo_cob(COB_RPDO1, 2'(k), node_act_reg);
    end
    pend_set = {60'h0, rtr_hit};
    if (tx_type_reg == TXTYPE_EVENT)
      pend_set = pend_set | value_changed;
    if (tag_new || sync_fire)
      pend_set = '1;
    pend_set = pend_set & tpdo_ena_reg;
  end

  assign sync_fire = rx_sync && tx_type_reg != 8'h00 && tx_type_reg <= TXTYPE_SYNC_MAX &&
                     (sync_cnt_reg + 8'h01 >= tx_type_reg);

  always_ff @(posedge clk_sys)
  begin
    if (reset || state_reg == ST_INIT)
      sync_cnt_reg <= 8'h00;
    else if (sync_fire)
      sync_cnt_reg <= 8'h00;
    else if (rx_sync)
      sync_cnt_reg <= sync_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || !oper)
      pend_reg <= 64'h0;
    else if (serve_reg == SV_IDLE && pend_reg != 64'h0)
      pend_reg <= (pend_reg & ~(64'h1 << first_one(pend_reg))) | pend_set;
    else
      pend_reg <= pend_reg | pend_set;
  end

  // PDO server: fetch tag bytes for the lowest pending TPDO and queue a frame.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      serve_reg     <= SV_IDLE;
      serve_pdo_reg <= 6'h00;
      tag_rd_valid  <= 1'b0;
      tag_rd_pdo    <= 6'h00;
      pdo_frame_reg <= '0;
    end
    else
    begin
      tag_rd_valid <= 1'b0;
      case (serve_reg)
        SV_IDLE:
        begin
          if (oper && pend_reg != 64'h0)
          begin
            serve_pdo_reg <= first_one(pend_reg);
            tag_rd_pdo    <= first_one(pend_reg);
            tag_rd_valid  <= 1'b1;
            serve_reg     <= SV_WAIT;
          end
        end
        SV_WAIT:
        begin
          if (!oper)
            serve_reg <= SV_IDLE;
          else if (tag_rd_done)
          begin
            pdo_frame_reg.cob  <= pdo_cob(COB_TPDO1, serve_pdo_reg[1:0], node_act_reg);
            pdo_frame_reg.rtr  <= 1'b0;
            pdo_frame_reg.dlc  <= 4'h8;
            pdo_frame_reg.data <= tag_rd_data;
            serve_reg          <= SV_PUSH;
          end
        end
        default:
        begin
          if (!oper || take_pdo)
            serve_reg <= SV_IDLE;
        end
      endcase
    end
  end

  // RPDO reception writes the mapped tag area.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tag_wr_valid <= 1'b0;
      tag_wr_pdo   <= 6'h00;
      tag_wr_data  <= 64'h0;
    end
    else
    begin
      tag_wr_valid <= oper && (rpdo_hit != 4'h0);
      if (rpdo_hit != 4'h0)
      begin
        tag_wr_pdo  <= {4'h0, rx_frame.cob[9:8] - 2'h2};
        tag_wr_data <= rx_frame.data;
      end
    end
  end

  // Transmit source priority: boot-up, layer setting answer, then PDO.
  assign take_boot = boot_pend_reg && in_ready;
  assign take_lss  = !boot_pend_reg && lss_pend_reg && in_ready;
  assign take_pdo  = !boot_pend_reg && !lss_pend_reg && oper &&
                     serve_reg == SV_PUSH && in_ready;
  assign in_valid  = boot_pend_reg || lss_pend_reg || (oper && serve_reg == SV_PUSH);

  always_comb
  begin
    in_frame = pdo_frame_reg;
    if (boot_pend_reg)
      in_frame = '{cob: COB_BOOT + {4'h0, node_act_reg[6:0]}, rtr: 1'b0,
                   dlc: 4'h1, data: 64'h0};
    else if (lss_pend_reg)
      in_frame = lss_rsp_reg;
  end

  // Two-entry transmit buffer; a stalled controller loses no frame.
  assign in_ready = (buf_cnt_reg != 2'd2);
  assign tx_valid = (buf_cnt_reg != 2'd0);
  assign tx_frame = buf_mem[buf_rd_reg];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      buf_wr_reg  <= 1'b0;
      buf_rd_reg  <= 1'b0;
      buf_cnt_reg <= 2'd0;
      buf_mem[0]  <= '0;
      buf_mem[1]  <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        buf_mem[buf_wr_reg] <= in_frame;
        buf_wr_reg          <= ~buf_wr_reg;
      end
      if (tx_valid && tx_ready)
        buf_rd_reg <= ~buf_rd_reg;
      buf_cnt_reg <= buf_cnt_reg + 2'(in_valid && in_ready) - 2'(tx_valid && tx_ready);
    end
  end

  // Flash timebases and a pseudo-random source for irregular flashing.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fast_cnt_reg <= 32'h0;
      slow_cnt_reg <= 32'h0;
      fast_ph_reg  <= 1'b0;
      slow_ph_reg  <= 1'b0;
      lfsr_reg     <= LFSR_SEED;
    end
    else
    begin
      fast_cnt_reg <= (fast_cnt_reg >= FAST_HALF - 1) ? 32'h0 : fast_cnt_reg + 32'h1;
      slow_cnt_reg <= (slow_cnt_reg >= SLOW_HALF - 1) ? 32'h0 : slow_cnt_reg + 32'h1;
      if (fast_cnt_reg >= FAST_HALF - 1)
      begin
        fast_ph_reg <= ~fast_ph_reg;
        lfsr_reg    <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                        lfsr_reg[12] ^ lfsr_reg[10]};
      end
      if (slow_cnt_reg >= SLOW_HALF - 1)
        slow_ph_reg <= ~slow_ph_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      led_green  <= 1'b0;
      led_red    <= 1'b0;
      led_yellow <= 1'b0;
    end
    else
    begin
      if (cfg_error)
      begin
        led_green <= fast_ph_reg;
        led_red   <= ~fast_ph_reg;
      end
      else if (bus_error)
      begin
        led_green <= slow_ph_reg;
        led_red   <= ~slow_ph_reg;
      end
      else
      begin
        led_red   <= bus_off || (lss_cfg_reg && lfsr_reg[0]);
        led_green <= (state_reg == ST_PREOP) || (oper && fast_ph_reg);
      end
      led_yellow <= hw_fault ? lfsr_reg[1] : tag_present;
    end
  end

  assign net_state     = state_reg;
  assign node_id       = node_act_reg;
  assign bit_rate_code = rate_act_reg;
  assign bit_rate_kbps = kbps_of(rate_act_reg);
endmodule : rhc_node

/* verilog/rhc_pkg.sv */
// Shared constants and types for the RFID head network node.
// Assumes a 100 MHz system clock and a frame-level CAN controller outside.
package rhc_pkg;
  localparam logic [15:0] OD_NODE_A    = 16'h20f0;
  localparam logic [15:0] OD_NODE_B    = 16'h20f1;
  localparam logic [15:0] OD_RATE_A    = 16'h20f2;
  localparam logic [15:0] OD_RATE_B    = 16'h20f3;
  localparam logic [15:0] OD_STATUS    = 16'h2100;
  localparam logic [15:0] OD_RPDO_PAR  = 16'h1400;
  localparam logic [15:0] OD_TPDO_PAR  = 16'h1800;
  localparam logic [7:0]  SUB_COB      = 8'h01;
  localparam logic [7:0]  SUB_TXTYPE   = 8'h02;
  localparam logic [7:0]  NODE_ID_RST  = 8'h20;
  localparam logic [7:0]  RATE_RST     = 8'h04;
  localparam logic [7:0]  NODE_MIN     = 8'h01;
  localparam logic [7:0]  NODE_MAX     = 8'h7f;
  localparam logic [7:0]  RATE_MAX     = 8'h07;
  localparam logic [63:0] PDO_ENA_RST  = 64'h0000_0000_0000_000f;
  localparam logic [7:0]  TXTYPE_EVENT = 8'hff;
  localparam logic [7:0]  TXTYPE_SYNC_MAX = 8'hf0;
  localparam logic [10:0] COB_NMT      = 11'h000;
  localparam logic [10:0] COB_SYNC     = 11'h080;
  localparam logic [10:0] COB_TPDO1    = 11'h180;
  localparam logic [10:0] COB_RPDO1    = 11'h200;
  localparam logic [10:0] COB_BOOT     = 11'h700;
  localparam logic [10:0] COB_LSS_TX   = 11'h7e4;
  localparam logic [10:0] COB_LSS_RX   = 11'h7e5;
  localparam logic [7:0]  NMT_START    = 8'h01;
  localparam logic [7:0]  NMT_STOP     = 8'h02;
  localparam logic [7:0]  NMT_PREOP    = 8'h80;
  localparam logic [7:0]  NMT_RST_NODE = 8'h81;
  localparam logic [7:0]  NMT_RST_COMM = 8'h82;
  localparam logic [7:0]  LSS_SWITCH   = 8'h04;
  localparam logic [7:0]  LSS_CFG_NODE = 8'h11;
  localparam logic [7:0]  LSS_CFG_BIT  = 8'h13;
  localparam logic [7:0]  LSS_ACT_BIT  = 8'h15;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned FAST_HALF_MS = 200;
  localparam int unsigned SLOW_HALF_MS = 625;
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;

  typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_OPER, ST_STOPPED} rhc_state_t;
  typedef enum logic [1:0] {SV_IDLE, SV_WAIT, SV_PUSH} rhc_serve_t;

  typedef struct packed {
    logic [10:0] cob;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } rhc_frame_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } rhc_od_req_t;
endpackage : rhc_pkg
